// [verilog/msf_pkg.sv]
// Constants and carrier types for the monitor status flag block
package msf_pkg;

  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] MSF_ADDR_FLAGS1 = 8'h41;
  localparam logic [7:0] MSF_ADDR_FLAGS2 = 8'h42;
  localparam logic [7:0] MSF_ADDR_CODE = 8'h43;
  localparam logic [7:0] MSF_FLAGS1_RESET = 8'h00;
  localparam logic [7:0] MSF_FLAGS2_RESET = 8'h00;
  localparam logic [7:0] MSF_CODE_RESET = 8'h00;
  localparam logic [7:0] MSF_UNMAPPED_DATA = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned MSF_F1_VOLT_LSB = 0;
  localparam int unsigned MSF_F1_TEMP_LSB = 4;
  localparam int unsigned MSF_F1_ANY2_BIT = 7;
  localparam int unsigned MSF_F2_V12_BIT = 0;
  localparam int unsigned MSF_F2_OVERTEMP_BIT = 1;
  localparam int unsigned MSF_F2_FAN_LSB = 2;
  localparam int unsigned MSF_F2_DIODE_LSB = 6;
  localparam int unsigned MSF_CODE_W = 5;
  localparam int unsigned MSF_CODE_RSVD_W = 3;

  // ----------------------------------------
  // Channel counts and compare constants
  // ----------------------------------------
  localparam int unsigned MSF_NUM_VOLT = 5;
  localparam int unsigned MSF_NUM_TEMP = 3;
  localparam int unsigned MSF_NUM_FAN = 4;
  localparam int unsigned MSF_NUM_PWM = 3;
  localparam logic signed [8:0] MSF_OVERTEMP_HYST = 9'sh004;
  localparam logic [7:0] MSF_DIODE_FAULT_CODE = 8'h80;
  localparam logic [15:0] MSF_TACH_LIMIT_OFF_HI = 16'hFFFF;
  localparam logic [15:0] MSF_TACH_LIMIT_OFF_LO = 16'h0000;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] reading;
    logic [7:0] low;
    logic [7:0] high;
  } msf_volt_chan_t;

  typedef struct packed {
    logic [7:0] reading;
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] overtemp_threshold;
  } msf_temp_chan_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] min;
  } msf_fan_chan_t;

  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } msf_reg_req_t;

endpackage

// [verilog/msf_flag_cell.sv]
// Sticky flags with conditional clear on read
`timescale 1ns/10ps
module msf_flag_cell #(
  parameter int unsigned W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_active,
  input wire logic i_rd_clr,
  output logic [W-1:0] o_flag
);
  import msf_pkg::*;

  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    flag_d = i_set | (flag_q & ~({W{i_rd_clr}} & ~i_active));
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;
endmodule

// [verilog/msf_top.sv]
// Status flag registers and identification readback of a hardware monitor
// What this block does
// - Flags1 bits 0-3 set when 2.5V, core, own supply or 5V leave limits.
// - A read clears a limit flag only when its condition has gone.
// - Flags1 bits 4-6 set on remote one, local, remote two temperature limits.
// - Flags1 bit 7 reads as OR of all flags2 bits.
// - Flags2 bit 0 sets on 12V limit, same conditional clear on read.
// - Overtemp flag latches; read clears only below threshold minus 4.
// - Flags2 bits 2-5 set when fans one to four are slow or stalled.
// - No fan flag while its PWM is off; fan four follows PWM three.
// - Flags2 bits 6 and 7 flag remote diode one and two faults.
// - Readback bits 4:0 mirror the five voltage code pins one cycle late, once reset is released.
// - Readback bits 7:5 are reserved, read-only, read as zero.
// - Flags2 and readback reset to 0x00; all bits read-only.
// - High event when reading above high; low event when at or below low.
// - Fan fault when tach count exceeds the minimum-speed limit by one or more.
`timescale 1ns/10ps
module msf_top (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire msf_pkg::msf_reg_req_t i_reg_req,
  input wire msf_pkg::msf_volt_chan_t [msf_pkg::MSF_NUM_VOLT-1:0] i_volt,
  input wire msf_pkg::msf_temp_chan_t [msf_pkg::MSF_NUM_TEMP-1:0] i_temp,
  input wire msf_pkg::msf_fan_chan_t [msf_pkg::MSF_NUM_FAN-1:0] i_fan,
  input wire logic [msf_pkg::MSF_NUM_PWM-1:0] i_pwm_on,
  input wire logic [msf_pkg::MSF_CODE_W-1:0] i_cpu_voltage_code,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid
);
  import msf_pkg::*;

  // ----------------------------------------
  // Limit comparisons
  // ----------------------------------------
  logic [MSF_NUM_VOLT-1:0] volt_oor;
  logic [MSF_NUM_TEMP-1:0] temp_oor;
  logic [MSF_NUM_TEMP-1:0] temp_over;
  logic [MSF_NUM_TEMP-1:0] temp_hot;
  logic [MSF_NUM_FAN-1:0] fan_pwm;
  logic [MSF_NUM_FAN-1:0] fan_fault;
  logic [1:0] diode_fault;
  logic overtemp_set;
  logic overtemp_active;

  assign fan_pwm = {i_pwm_on[MSF_NUM_PWM-1], i_pwm_on};

  always_comb begin
    for (int i = 0; i < MSF_NUM_VOLT; i++) begin
      volt_oor[i] = (i_volt[i].reading > i_volt[i].high) ||
                    (i_volt[i].reading <= i_volt[i].low);
    end
    for (int i = 0; i < MSF_NUM_TEMP; i++) begin
      temp_oor[i] = ($signed(i_temp[i].reading) > $signed(i_temp[i].high)) ||
                    ($signed(i_temp[i].reading) <= $signed(i_temp[i].low));
      temp_over[i] = $signed(i_temp[i].reading) > $signed(i_temp[i].overtemp_threshold);
      temp_hot[i] = $signed({i_temp[i].reading[7], i_temp[i].reading}) >=
                    ($signed({i_temp[i].overtemp_threshold[7],
                              i_temp[i].overtemp_threshold}) - MSF_OVERTEMP_HYST);
    end
    for (int i = 0; i < MSF_NUM_FAN; i++) begin
      fan_fault[i] = fan_pwm[i] &&
                     (i_fan[i].min != MSF_TACH_LIMIT_OFF_HI) &&
                     (i_fan[i].min != MSF_TACH_LIMIT_OFF_LO) &&
                     (i_fan[i].count > i_fan[i].min);
    end
  end

  assign diode_fault[0] = i_temp[0].reading == MSF_DIODE_FAULT_CODE;
  assign diode_fault[1] = i_temp[MSF_NUM_TEMP-1].reading == MSF_DIODE_FAULT_CODE;
  assign overtemp_set = |temp_over;
  assign overtemp_active = |temp_hot;

  // ----------------------------------------
  // Read decode; writes are not decoded
  // ----------------------------------------
  logic rd1;
  logic rd2;
  assign rd1 = i_reg_req.rd && (i_reg_req.addr == MSF_ADDR_FLAGS1);
  assign rd2 = i_reg_req.rd && (i_reg_req.addr == MSF_ADDR_FLAGS2);

  // ----------------------------------------
  // Flag registers
  // ----------------------------------------
  logic [6:0] set1;
  logic [7:0] set2;
  logic [7:0] active2;
  logic [6:0] flags1_q;
  logic [7:0] flags2_q;

  assign set1 = {temp_oor, volt_oor[3:0]};
  assign set2 = {diode_fault, fan_fault, overtemp_set,
                 volt_oor[MSF_NUM_VOLT-1]};
  assign active2 = {diode_fault, fan_fault, overtemp_active,
                    volt_oor[MSF_NUM_VOLT-1]};

  msf_flag_cell #(.W(7)) u_flags1 (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_set(set1),
    .i_active(set1),
    .i_rd_clr(rd1),
    .o_flag(flags1_q)
  );

  msf_flag_cell #(.W(8)) u_flags2 (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_set(set2),
    .i_active(active2),
    .i_rd_clr(rd2),
    .o_flag(flags2_q)
  );

  // ----------------------------------------
  // Identification readback and read data
  // ----------------------------------------
  logic [7:0] code_q;
  logic [7:0] code_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    code_d = {{MSF_CODE_RSVD_W{1'b0}}, i_cpu_voltage_code};
    rvalid_d = i_reg_req.rd;
    rdata_d = rdata_q;
    if (i_reg_req.rd) begin
      unique case (i_reg_req.addr)
        MSF_ADDR_FLAGS1: rdata_d = {|flags2_q, flags1_q};
        MSF_ADDR_FLAGS2: rdata_d = flags2_q;
        MSF_ADDR_CODE: rdata_d = code_q;
        default: rdata_d = MSF_UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      code_q <= MSF_CODE_RESET;
      rdata_q <= MSF_UNMAPPED_DATA;
      rvalid_q <= 1'b0;
    end else begin
      code_q <= code_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_volt_set;
    volt_oor[0] |=> flags1_q[0];
  endproperty
  a_volt_set: assert property (p_volt_set) else $error("2.5V flag not set");

  property p_hold_active;
    (rd1 && flags1_q[1] && volt_oor[1]) |=> flags1_q[1];
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("active flag cleared");

  property p_clear_gone;
    (rd1 && flags1_q[2] && !set1[2]) |=> !flags1_q[2];
  endproperty
  a_clear_gone: assert property (p_clear_gone) else $error("subsided flag kept");

  property p_temp_set;
    temp_oor[1] |=> flags1_q[5];
  endproperty
  a_temp_set: assert property (p_temp_set) else $error("local temp flag not set");

  property p_any2;
    rd1 |=> (o_reg_rvalid && o_reg_rdata[7] == $past(|flags2_q));
  endproperty
  a_any2: assert property (p_any2) else $error("summary bit wrong");

  property p_v12_set;
    volt_oor[4] |=> flags2_q[0];
  endproperty
  a_v12_set: assert property (p_v12_set) else $error("12V flag not set");

  property p_hot_hold;
    (rd2 && flags2_q[1] && overtemp_active) |=> flags2_q[1];
  endproperty
  a_hot_hold: assert property (p_hot_hold) else $error("overtemp cleared early");

  property p_hot_clear;
    (rd2 && flags2_q[1] && !overtemp_active) |=> !flags2_q[1];
  endproperty
  a_hot_clear: assert property (p_hot_clear) else $error("overtemp kept after cooling");

  property p_fan_set;
    fan_fault[0] |=> flags2_q[2];
  endproperty
  a_fan_set: assert property (p_fan_set) else $error("fan one flag not set");

  property p_fan_four_fault_pwm_off;
    (!i_pwm_on[2] && !flags2_q[5]) |=> !flags2_q[5];
  endproperty
  a_fan_four_fault_pwm_off: assert property (p_fan_four_fault_pwm_off) else $error("fan four set, pwm off");

  property p_diode2;
    (i_temp[2].reading == 8'h80) |=> flags2_q[7];
  endproperty
  a_diode2: assert property (p_diode2) else $error("diode two flag not set");

  property p_code_mirror;
    1'b1 |=> code_q[4:0] == $past(i_cpu_voltage_code);
  endproperty
  a_code_mirror: assert property (p_code_mirror) else $error("code not mirrored");

  property p_code_rsvd;
    code_q[7:5] == 3'h0;
  endproperty
  a_code_rsvd: assert property (p_code_rsvd) else $error("reserved bits set");

  property p_reset_vals;
    $rose(i_reset_n) |-> (flags2_q == 8'h00 && code_q == 8'h00);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_low_equal;
    (i_volt[3].reading == i_volt[3].low) |=> flags1_q[3];
  endproperty
  a_low_equal: assert property (p_low_equal) else $error("equal-low not flagged");

  property p_tach_by_one;
    (i_pwm_on[1] && i_fan[1].min == 16'h1000 && i_fan[1].count == 16'h1001) |=> flags2_q[3];
  endproperty
  a_tach_by_one: assert property (p_tach_by_one) else $error("tach +1 not flagged");

  property p_write_ignored;
    (i_reg_req.wr && !i_reg_req.rd && set2 == 8'h00) |=> flags2_q == $past(flags2_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored) else $error("write altered flags");

  c_flag_cleared: cover property (flags1_q[0] ##1 rd1 ##1 !flags1_q[0]);
  c_hot_hold: cover property (rd2 && flags2_q[1] && overtemp_active);
  c_summary_read: cover property (rd1 && |flags2_q);
  c_fan_fault: cover property (fan_fault[3] ##1 flags2_q[5]);
endmodule

// [test/msf_host_model.sv]
// Host model issuing single-byte register reads and writes
`timescale 1ns/10ps
module msf_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output msf_pkg::msf_reg_req_t o_reg_req
);
  import msf_pkg::*;
  initial begin
    o_reg_req = '0;
  end
  // Read pulse held one cycle, then released with scrambled address
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(posedge i_sys_clk);
    o_reg_req <= '{addr: addr, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
    @(posedge i_sys_clk);
    o_reg_req <= '{addr: ~addr, rd: 1'b0, wr: 1'b0, wdata: 8'hFF};
    ok = 1'b0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_reg_rvalid === 1'b1) begin
        ok = 1'b1;
        data = i_reg_rdata;
      end else begin
        @(posedge i_sys_clk);
      end
    end
  endtask
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] wd);
    @(posedge i_sys_clk);
    o_reg_req <= '{addr: addr, rd: 1'b0, wr: 1'b1, wdata: wd};
    @(posedge i_sys_clk);
    o_reg_req <= '{addr: ~addr, rd: 1'b0, wr: 1'b0, wdata: ~wd};
  endtask
endmodule

// [test/msf_top_tb.sv]
// Self-checking testbench of the monitor status flag block
`timescale 1ns/10ps
module msf_top_tb;
  import msf_pkg::*;
  logic i_sys_clk;
  logic i_reset_n;
  msf_reg_req_t reg_req;
  msf_volt_chan_t [MSF_NUM_VOLT-1:0] volt;
  msf_temp_chan_t [MSF_NUM_TEMP-1:0] temp;
  msf_fan_chan_t [MSF_NUM_FAN-1:0] fan;
  logic [MSF_NUM_PWM-1:0] pwm_on;
  logic [MSF_CODE_W-1:0] cpu_code;
  logic [7:0] rdata;
  logic rvalid;
  int n_mismatch;
  int tests_run;
  int cycles;
  msf_top dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_req(reg_req),
    .i_volt(volt), .i_temp(temp), .i_fan(fan), .i_pwm_on(pwm_on),
    .i_cpu_voltage_code(cpu_code), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid));
  msf_host_model host (.i_sys_clk(i_sys_clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
    .o_reg_req(reg_req));
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.read_reg(addr, d, ok);
    cmp("rvalid", 8'h01, {7'h00, ok});
    cmp($sformatf("reg %h", addr), exp, d);
  endtask
  initial begin
    for (int i = 0; i < MSF_NUM_VOLT; i++) begin
      volt[i] <= '{reading: 8'h80, low: 8'h00, high: 8'hFF};
    end
    for (int i = 0; i < MSF_NUM_TEMP; i++) begin
      temp[i] <= '{reading: 8'h20, low: 8'h81, high: 8'h7F, overtemp_threshold: 8'h7F};
    end
    for (int i = 0; i < MSF_NUM_FAN; i++) begin
      fan[i] <= '{count: 16'h0100, min: 16'h1000};
    end
    pwm_on <= 3'h7;
    cpu_code <= 5'h15;
    i_reset_n <= 1'b0;
    repeat (16) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    chk(MSF_ADDR_FLAGS1, 8'h00);
    chk(MSF_ADDR_FLAGS2, 8'h00);
    chk(MSF_ADDR_CODE, 8'h15);
    chk(8'h44, MSF_UNMAPPED_DATA);
    @(posedge i_sys_clk) cpu_code <= 5'h0A;
    chk(MSF_ADDR_CODE, 8'h0A);
    $display("test reset done");
    for (int i = 0; i < MSF_NUM_VOLT; i++) begin
      logic [7:0] a;
      logic [7:0] m;
      a = (i < 4) ? MSF_ADDR_FLAGS1 : MSF_ADDR_FLAGS2;
      m = (i < 4) ? (8'h01 << i) : 8'h01;
      @(posedge i_sys_clk) volt[i].low <= 8'h80;
      if (i == 4) chk(MSF_ADDR_FLAGS1, 8'h80);
      chk(a, m);
      chk(a, m);
      @(posedge i_sys_clk) volt[i].low <= 8'h7F;
      volt[i].high <= 8'h80;
      chk(a, m);
      chk(a, 8'h00);
      @(posedge i_sys_clk) volt[i].high <= 8'h7F;
      @(posedge i_sys_clk) volt[i].high <= 8'h80;
      chk(a, m);
      chk(a, 8'h00);
    end
    $display("test volt done");
    for (int i = 0; i < MSF_NUM_TEMP; i++) begin
      @(posedge i_sys_clk) temp[i].low <= 8'h20;
      chk(MSF_ADDR_FLAGS1, 8'h10 << i);
      @(posedge i_sys_clk) temp[i].low <= 8'h81;
      temp[i].high <= 8'h1F;
      @(posedge i_sys_clk) temp[i].high <= 8'h20;
      chk(MSF_ADDR_FLAGS1, 8'h10 << i);
      chk(MSF_ADDR_FLAGS1, 8'h00);
    end
    @(posedge i_sys_clk) temp[1].overtemp_threshold <= 8'h1F;
    @(posedge i_sys_clk) temp[1].overtemp_threshold <= 8'h24;
    chk(MSF_ADDR_FLAGS2, 8'h02);
    chk(MSF_ADDR_FLAGS2, 8'h02);
    chk(MSF_ADDR_FLAGS1, 8'h80);
    @(posedge i_sys_clk) temp[1].overtemp_threshold <= 8'h25;
    chk(MSF_ADDR_FLAGS2, 8'h02);
    chk(MSF_ADDR_FLAGS2, 8'h00);
    $display("test overtemp done");
    for (int i = 0; i < MSF_NUM_FAN; i++) begin
      int p;
      p = (i == 3) ? 2 : i;
      @(posedge i_sys_clk) pwm_on[p] <= 1'b0;
      fan[i].count <= 16'h1001;
      chk(MSF_ADDR_FLAGS2, 8'h00);
      @(posedge i_sys_clk) pwm_on[p] <= 1'b1;
      chk(MSF_ADDR_FLAGS2, 8'h04 << i);
      @(posedge i_sys_clk) fan[i].count <= 16'h1000;
      chk(MSF_ADDR_FLAGS2, 8'h04 << i);
      chk(MSF_ADDR_FLAGS2, 8'h00);
    end
    @(posedge i_sys_clk) fan[0].count <= 16'h1001;
    fan[0].min <= 16'h0000;
    chk(MSF_ADDR_FLAGS2, 8'h00);
    @(posedge i_sys_clk) fan[0].count <= 16'h0100;
    fan[0].min <= 16'h1000;
    $display("test fan done");
    @(posedge i_sys_clk) temp[0].reading <= 8'h80;
    temp[2].reading <= 8'h80;
    @(posedge i_sys_clk) temp[0].reading <= 8'h20;
    temp[2].reading <= 8'h20;
    chk(MSF_ADDR_FLAGS1, 8'hD0);
    chk(MSF_ADDR_FLAGS2, 8'hC0);
    chk(MSF_ADDR_FLAGS2, 8'h00);
    chk(MSF_ADDR_FLAGS1, 8'h00);
    $display("test diode done");
    @(posedge i_sys_clk) volt[0].low <= 8'h80;
    @(posedge i_sys_clk) volt[0].low <= 8'h00;
    host.write_reg(MSF_ADDR_FLAGS1, 8'h00);
    host.write_reg(MSF_ADDR_FLAGS2, 8'hFF);
    host.write_reg(MSF_ADDR_CODE, 8'hFF);
    chk(MSF_ADDR_FLAGS1, 8'h01);
    chk(MSF_ADDR_FLAGS2, 8'h00);
    chk(MSF_ADDR_CODE, 8'h0A);
    $display("test write done");
    end_of_test();
  end
endmodule
